// ===== verilog/ubd_top.sv
// usb descriptor table, ping-pong map and two-level interrupt flags
//
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module ubd_top (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // ahb-lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [31:0]      o_hrdata,
  // engine condition pulses
  input  wire logic [6:0]  i_stat_evt,
  input  wire logic [7:0]  i_err_evt,
  // engine descriptor access
  input  wire logic        i_eng_req,
  input  wire logic        i_eng_done,
  input  wire logic [3:0]  i_eng_ep,
  input  wire logic        i_eng_dir,
  input  wire logic [3:0]  i_eng_pid,
  input  wire logic [9:0]  i_eng_bc,
  // descriptor lookup answer
  output logic             o_eng_valid,
  output logic [5:0]       o_eng_slot,
  output logic             o_eng_owned,
  output logic             o_eng_tsync_en,
  output logic             o_eng_toggle,
  output logic             o_eng_stall,
  output logic [9:0]       o_eng_count,
  output logic [15:0]      o_eng_addr,
  // module state and request
  output logic             o_enabled,
  output logic             o_suspend,
  output logic             o_irq
);

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [1:0]                   pp_mode;
  logic [ubd_pkg::SFLAG_W-1:0]  sflag;
  logic [ubd_pkg::SFLAG_W-1:0]  sen;
  logic [ubd_pkg::EFLAG_W-1:0]  eflag;
  logic [ubd_pkg::EFLAG_W-1:0]  een;
  logic [2*ubd_pkg::NUM_EP-1:0] pp_odd;
  logic [ubd_pkg::DW-1:0]       desc [ubd_pkg::NUM_DESC];
  ubd_pkg::ubd_bus_e            bus_st;
  ubd_pkg::ubd_bus_e            next_bus_st;
  logic [ubd_pkg::AW-1:0]       a_addr;
  logic                         a_word;

  function automatic logic hit(input logic [ubd_pkg::AW-1:0] a,
                               input logic [ubd_pkg::AW-1:0] off);
    return a == off;
  endfunction

  // ------------------------------------------------------------
  // bus address phase
  // ------------------------------------------------------------
  wire accept;
  assign accept = i_hsel & i_htrans[1] & i_hready;

  // reads take one wait state so a write just before is seen
  always_comb begin
    case (bus_st)
      ubd_pkg::UBD_BUS_RD_WAIT: next_bus_st = ubd_pkg::UBD_BUS_RD_DATA;
      ubd_pkg::UBD_BUS_IDLE,
      ubd_pkg::UBD_BUS_WR,
      ubd_pkg::UBD_BUS_RD_DATA: begin
        if (accept) begin
          next_bus_st = i_hwrite ? ubd_pkg::UBD_BUS_WR : ubd_pkg::UBD_BUS_RD_WAIT;
        end else begin
          next_bus_st = ubd_pkg::UBD_BUS_IDLE;
        end
      end
      default: next_bus_st = ubd_pkg::UBD_BUS_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bus_st      <= ubd_pkg::UBD_BUS_IDLE;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      bus_st      <= next_bus_st;
      o_hreadyout <= next_bus_st != ubd_pkg::UBD_BUS_RD_WAIT;
      o_hresp     <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      a_addr <= '0;
      a_word <= 1'b0;
    end else if (accept) begin
      a_addr <= i_haddr[ubd_pkg::AW-1:0];
      a_word <= i_hsize == ubd_pkg::HSIZE_WORD;
    end
  end

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire       is_desc;
  wire [5:0] d_idx;
  wire       wr_go;
  wire       w_ctrl;
  wire       w_cfg;
  wire       w_sflag;
  wire       w_sen;
  wire       w_eflag;
  wire       w_een;
  wire       w_desc;

  assign is_desc = (a_addr >= ubd_pkg::DESC_BASE) && (a_addr < ubd_pkg::DESC_END);
  assign d_idx   = a_addr[ubd_pkg::DIDX_MSB:ubd_pkg::DIDX_LSB];
  // narrow writes are dropped; the bus always answers okay
  assign wr_go   = (bus_st == ubd_pkg::UBD_BUS_WR) & a_word;
  assign w_ctrl  = wr_go & hit(a_addr, ubd_pkg::CTRL_OFF);
  assign w_cfg   = wr_go & hit(a_addr, ubd_pkg::CFG_OFF);
  assign w_sflag = wr_go & hit(a_addr, ubd_pkg::SFLAG_OFF);
  assign w_sen   = wr_go & hit(a_addr, ubd_pkg::SEN_OFF);
  assign w_eflag = wr_go & hit(a_addr, ubd_pkg::EFLAG_OFF);
  assign w_een   = wr_go & hit(a_addr, ubd_pkg::EEN_OFF);
  assign w_desc  = wr_go & is_desc;

  // ------------------------------------------------------------
  // control and configuration
  // ------------------------------------------------------------
  wire pp_clr;
  // pointers go even on enable rising or on explicit reset bit
  assign pp_clr = w_ctrl & ((i_hwdata[ubd_pkg::CTRL_EN] & ~o_enabled) |
                            i_hwdata[ubd_pkg::CTRL_PPRST]);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_enabled <= 1'b0;
      o_suspend <= 1'b0;
    end else if (w_ctrl) begin
      o_enabled <= i_hwdata[ubd_pkg::CTRL_EN];
      o_suspend <= i_hwdata[ubd_pkg::CTRL_SUSP];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pp_mode <= ubd_pkg::PP_NONE;
    end else if (w_cfg) begin
      pp_mode <= i_hwdata[1:0];
    end
  end

  // ------------------------------------------------------------
  // engine side gating and slot map
  // ------------------------------------------------------------
  wire                   eng_live;
  wire                   req_go;
  wire                   done_go;
  wire [4:0]             pp_idx;
  wire [5:0]             map_slot;
  wire [ubd_pkg::DW-1:0] cur;
  wire [ubd_pkg::DW-1:0] done_word;
  ubd_map_if             mif ();

  assign eng_live = o_enabled & ~o_suspend;
  assign req_go   = i_eng_req & eng_live;
  assign done_go  = i_eng_done & eng_live;
  assign pp_idx   = {i_eng_ep, i_eng_dir};

  assign mif.ep   = i_eng_ep;
  assign mif.dir  = i_eng_dir;
  assign mif.odd  = pp_odd[pp_idx];
  assign mif.mode = pp_mode;
  assign map_slot = mif.slot;

  ubd_slot_map u_map (
    .m (mif)
  );

  assign cur = desc[map_slot];
  assign done_word = {cur[ubd_pkg::DW-1:ubd_pkg::ADR_LSB],
                      i_eng_bc[ubd_pkg::CNT_W-1:0],
                      1'b0,
                      cur[ubd_pkg::DTS_BIT],
                      i_eng_pid,
                      i_eng_bc[ubd_pkg::BC_W-1:ubd_pkg::CNT_W]};

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pp_odd <= '0;
    end else if (pp_clr) begin
      pp_odd <= '0;
    end else if (done_go) begin
      pp_odd[pp_idx] <= ~pp_odd[pp_idx];
    end
  end

  // ------------------------------------------------------------
  // descriptor table
  // ------------------------------------------------------------
  // no reset on descriptors
  // four bytes per word
  // engine completion lands last, so it wins a same-slot collision
  always_ff @(posedge i_clk) begin
    if (w_desc) begin
      desc[d_idx] <= i_hwdata;
    end
    if (done_go) begin
      desc[map_slot] <= done_word;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_eng_valid    <= 1'b0;
      o_eng_slot     <= '0;
      o_eng_owned    <= 1'b0;
      o_eng_tsync_en <= 1'b0;
      o_eng_toggle   <= 1'b0;
      o_eng_stall    <= 1'b0;
      o_eng_count    <= '0;
      o_eng_addr     <= '0;
    end else begin
      o_eng_valid <= req_go;
      if (req_go) begin
        o_eng_slot     <= map_slot;
        o_eng_owned    <= cur[ubd_pkg::OWN_BIT];
        o_eng_tsync_en <= cur[ubd_pkg::TSE_BIT];
        o_eng_toggle   <= cur[ubd_pkg::DTS_BIT] & cur[ubd_pkg::TSE_BIT];
        o_eng_stall    <= cur[ubd_pkg::STALL_BIT];
        o_eng_count    <= {cur[1:0], cur[ubd_pkg::ADR_LSB-1:ubd_pkg::CNT_W]};
        o_eng_addr     <= cur[ubd_pkg::DW-1:ubd_pkg::ADR_LSB];
      end
    end
  end

  // ------------------------------------------------------------
  // interrupt flags
  // ------------------------------------------------------------
  wire [ubd_pkg::SFLAG_W-1:0] s_set;
  wire [ubd_pkg::SFLAG_W-1:0] s_keep;
  wire [ubd_pkg::SFLAG_W-1:0] next_sflag;
  wire [ubd_pkg::SFLAG_W-1:0] next_sen;
  wire [ubd_pkg::EFLAG_W-1:0] e_set;
  wire [ubd_pkg::EFLAG_W-1:0] next_eflag;
  wire                        err_sum;

  assign s_set  = i_stat_evt & (o_suspend ? ubd_pkg::ACTV_MASK : ubd_pkg::SFLAG_HW_MASK);
  assign e_set  = o_suspend ? ubd_pkg::EFLAG_NONE : i_err_evt;
  assign s_keep = w_sflag ? i_hwdata[ubd_pkg::SFLAG_W-1:0] : sflag;
  assign next_eflag = (w_eflag ? i_hwdata[ubd_pkg::EFLAG_W-1:0] : eflag) | e_set;
  assign err_sum    = |(next_eflag & (w_een ? i_hwdata[ubd_pkg::EFLAG_W-1:0] : een));
  // summary bit is not writable by software
  assign next_sflag = ((s_keep | s_set) & ubd_pkg::SFLAG_HW_MASK) |
                      (err_sum ? ubd_pkg::SUM_MASK : ubd_pkg::SFLAG_NONE);
  assign next_sen   = w_sen ? i_hwdata[ubd_pkg::SFLAG_W-1:0] : sen;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sflag <= ubd_pkg::SFLAG_NONE;
      eflag <= ubd_pkg::EFLAG_NONE;
      sen   <= ubd_pkg::SFLAG_NONE;
      een   <= ubd_pkg::EFLAG_NONE;
    end else begin
      sflag <= next_sflag;
      eflag <= next_eflag;
      sen   <= next_sen;
      een   <= w_een ? i_hwdata[ubd_pkg::EFLAG_W-1:0] : een;
    end
  end

  // request tracks enabled flags
  // built from next values so the request never lags the flags
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(next_sflag & next_sen);
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  wire [ubd_pkg::DW-1:0] ctrl_word;
  wire [ubd_pkg::DW-1:0] rd_mux;

  assign ctrl_word = (32'(o_enabled) << ubd_pkg::CTRL_EN) |
                     (32'(o_suspend) << ubd_pkg::CTRL_SUSP);
  assign rd_mux = is_desc                             ? desc[d_idx] :
                  hit(a_addr, ubd_pkg::CTRL_OFF)      ? ctrl_word :
                  hit(a_addr, ubd_pkg::CFG_OFF)       ? 32'(pp_mode) :
                  hit(a_addr, ubd_pkg::SFLAG_OFF)     ? 32'(sflag) :
                  hit(a_addr, ubd_pkg::SEN_OFF)       ? 32'(sen) :
                  hit(a_addr, ubd_pkg::EFLAG_OFF)     ? 32'(eflag) :
                  hit(a_addr, ubd_pkg::EEN_OFF)       ? 32'(een) :
                  hit(a_addr, ubd_pkg::PFLAG2_OFF)    ? (32'(o_irq) << ubd_pkg::PERIPHERAL_FLAG_REG_TWO_BIT) :
                  hit(a_addr, ubd_pkg::PPSTAT_OFF)    ? pp_odd :
                  ubd_pkg::WORD_ZERO;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_hrdata <= ubd_pkg::WORD_ZERO;
    end else if (bus_st == ubd_pkg::UBD_BUS_RD_WAIT) begin
      o_hrdata <= rd_mux;
    end
  end

endmodule
`default_nettype wire

// ===== inc/ubd_pkg.sv
// constants for the usb descriptor map and interrupt block
package ubd_pkg;

  // ------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------
  localparam int NUM_EP    = 16;
  localparam int NUM_DESC  = 64;
  localparam int DW        = 32;
  localparam int AW        = 12;
  localparam int SFLAG_W   = 7;
  localparam int EFLAG_W   = 8;
  localparam int BC_W      = 10;
  localparam int CNT_W     = 8;
  localparam int PID_W     = 4;
  localparam int SLOT_W    = 6;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [AW-1:0] CTRL_OFF   = 12'h000;
  localparam logic [AW-1:0] CFG_OFF    = 12'h004;
  localparam logic [AW-1:0] SFLAG_OFF  = 12'h008;
  localparam logic [AW-1:0] SEN_OFF    = 12'h00C;
  localparam logic [AW-1:0] EFLAG_OFF  = 12'h010;
  localparam logic [AW-1:0] EEN_OFF    = 12'h014;
  localparam logic [AW-1:0] PFLAG2_OFF = 12'h018;
  localparam logic [AW-1:0] PPSTAT_OFF = 12'h01C;
  localparam logic [AW-1:0] DESC_BASE  = 12'h100;
  localparam logic [AW-1:0] DESC_END   = 12'h200;
  localparam int            DIDX_LSB   = 2;
  localparam int            DIDX_MSB   = 7;

  // ------------------------------------------------------------
  // control and configuration fields
  // ------------------------------------------------------------
  localparam int CTRL_SUSP  = 1;
  localparam int CTRL_EN    = 3;
  localparam int CTRL_PPRST = 6;
  localparam int PERIPHERAL_FLAG_REG_TWO_BIT   = 5;
  localparam logic [1:0] PP_NONE = 2'h0;
  localparam logic [1:0] PP_EP0  = 2'h1;
  localparam logic [1:0] PP_ALL  = 2'h2;

  // ------------------------------------------------------------
  // descriptor word layout
  // ------------------------------------------------------------
  localparam int OWN_BIT   = 7;
  localparam int DTS_BIT   = 6;
  localparam int TSE_BIT   = 3;
  localparam int STALL_BIT = 2;
  localparam int ADR_LSB   = 16;

  // ------------------------------------------------------------
  // status flag masks
  // ------------------------------------------------------------
  localparam logic [SFLAG_W-1:0] SFLAG_HW_MASK = 7'h7D;
  localparam logic [SFLAG_W-1:0] SUM_MASK      = 7'h02;
  localparam logic [SFLAG_W-1:0] ACTV_MASK     = 7'h04;
  localparam logic [SFLAG_W-1:0] SFLAG_NONE    = 7'h00;
  localparam logic [EFLAG_W-1:0] EFLAG_NONE    = 8'h00;
  localparam logic [DW-1:0]      WORD_ZERO     = 32'h0000_0000;
  localparam logic [2:0]         HSIZE_WORD    = 3'h2;

  // ------------------------------------------------------------
  // bus data phase states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    UBD_BUS_IDLE,
    UBD_BUS_WR,
    UBD_BUS_RD_WAIT,
    UBD_BUS_RD_DATA
  } ubd_bus_e;

endpackage

// ===== inc/ubd_map_if.sv
// carrier between the descriptor block and its slot mapper
`timescale 1ns/1ns
`default_nettype none
interface ubd_map_if;
  logic [3:0] ep;
  logic       dir;
  logic       odd;
  logic [1:0] mode;
  logic [5:0] slot;

  modport client (output ep, output dir, output odd, output mode, input slot);
  modport mapper (input ep, input dir, input odd, input mode, output slot);
endinterface
`default_nettype wire

// ===== verilog/ubd_slot_map.sv
// endpoint, direction and ping-pong state to descriptor slot
`timescale 1ns/1ns
`default_nettype none
module ubd_slot_map (
  ubd_map_if.mapper m
);

  // ------------------------------------------------------------
  // slot per buffering mode
  // ------------------------------------------------------------
  wire [5:0] s_none;
  wire [5:0] s_one;
  wire [5:0] s_all;
  wire       ep0_out;

  assign s_none  = {1'b0, m.ep, m.dir};
  assign ep0_out = (m.ep == 4'h0) && !m.dir;
  assign s_one   = ep0_out ? {5'h00, m.odd} : 6'(s_none + 6'h01);
  assign s_all   = {m.ep, m.dir, m.odd};

  // reserved mode code falls back to no ping-pong
  assign m.slot = (m.mode == ubd_pkg::PP_ALL) ? s_all :
                  (m.mode == ubd_pkg::PP_EP0) ? s_one : s_none;

endmodule
`default_nettype wire

// ===== bench/ubd_top_props.sv
// concurrent checks on the descriptor block ports
`timescale 1ns/1ns
`default_nettype none
module ubd_top_props (
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst,
  // bus
  input wire logic        i_hsel,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic        i_hready,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic [31:0] o_hrdata,
  // engine
  input wire logic [6:0]  i_stat_evt,
  input wire logic [7:0]  i_err_evt,
  input wire logic        i_eng_req,
  input wire logic        o_eng_valid,
  input wire logic [5:0]  o_eng_slot,
  input wire logic        o_eng_tsync_en,
  input wire logic        o_eng_toggle,
  input wire logic [9:0]  o_eng_count,
  input wire logic [15:0] o_eng_addr,
  // state
  input wire logic        o_enabled,
  input wire logic        o_suspend,
  input wire logic        o_irq
);
  // ----
  // helpers
  // ----
  logic take;
  logic acc;
  logic cause;
  logic wr_dph;
  assign take  = i_hsel & i_htrans[1] & i_hready;
  assign acc   = i_eng_req & o_enabled & ~o_suspend;
  // a flag write lands one edge after its address phase
  assign cause = wr_dph | (|i_stat_evt) | (|i_err_evt);
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_dph <= 1'b0;
    end else begin
      wr_dph <= take & i_hwrite;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // ----
  // properties
  // ----
  chk_read_wait: assert property (take && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout)
    else $error("read wait state wrong");
  chk_write_nowait: assert property (take && i_hwrite |=> o_hreadyout)
    else $error("write stalled");
  chk_resp_okay: assert property (o_hresp == 1'b0)
    else $error("response not okay");
  chk_rdata_hold: assert property (o_hreadyout && $past(o_hreadyout) |-> $stable(o_hrdata))
    else $error("read data moved");
  chk_lookup_answer: assert property (acc |=> o_eng_valid)
    else $error("lookup not answered");
  chk_valid_cause: assert property (o_eng_valid |-> $past(acc))
    else $error("answer without accepted lookup");
  chk_toggle_gate: assert property (o_eng_toggle |-> o_eng_tsync_en)
    else $error("toggle select not gated");
  chk_fields_hold: assert property (!o_eng_valid |-> $stable({o_eng_slot, o_eng_count, o_eng_addr}))
    else $error("lookup fields moved");
  chk_irq_cause: assert property ($changed(o_irq) |-> $past(cause) || $past(cause, 2))
    else $error("request changed without cause");

  cover property (acc);
  cover property ($rose(o_irq));
  cover property (o_suspend && i_stat_evt[2]);
endmodule

bind ubd_top ubd_top_props u_props (.*);
`default_nettype wire

// ===== bench/ubd_engine_model.sv
// engine-side stand-in: condition pulses, lookups, completions
`timescale 1ns/1ns
`default_nettype none
module ubd_engine_model (
  // clock
  input  wire logic  i_clk,
  // engine pulses
  output logic [6:0] o_stat,
  output logic [7:0] o_err,
  output logic       o_req,
  output logic       o_done,
  output logic [3:0] o_ep,
  output logic       o_dir,
  output logic [3:0] o_pid,
  output logic [9:0] o_bc
);
  initial begin
    {o_stat, o_err, o_req, o_done, o_ep, o_dir, o_pid, o_bc} = '0;
  end
  // activity pulse may come in suspend
  task automatic evt(input logic [6:0] s, input logic [7:0] e);
    o_stat <= s;
    o_err  <= e;
    @(posedge i_clk);
    {o_stat, o_err} <= '0;
  endtask
  // qualifiers are scrambled once released, so stale values never help
  task automatic lookup(input logic [3:0] ep, input logic d);
    {o_ep, o_dir, o_req} <= {ep, d, 1'b1};
    @(posedge i_clk);
    {o_ep, o_dir, o_req} <= {~ep, ~d, 1'b0};
  endtask
  // token id handed back with the count
  task automatic complete(input logic [3:0] ep, input logic d, input logic [3:0] p, input logic [9:0] b);
    {o_ep, o_dir, o_pid, o_bc, o_done} <= {ep, d, p, b, 1'b1};
    @(posedge i_clk);
    {o_ep, o_dir, o_pid, o_bc, o_done} <= {~ep, ~d, ~p, ~b, 1'b0};
  endtask
endmodule
`default_nettype wire

// ===== bench/ubd_top_bench.sv
// self-checking bench for the descriptor map and request block
`timescale 1ns/1ns
`default_nettype none
module ubd_top_bench;
  // ----
  // signals
  // ----
  logic        i_clk, i_rst, i_hsel, i_hwrite, o_hreadyout, o_hresp;
  logic        i_eng_req, i_eng_done, i_eng_dir, o_eng_valid, o_eng_owned;
  logic        o_eng_tsync_en, o_eng_toggle, o_eng_stall, o_enabled, o_suspend, o_irq;
  logic [1:0]  i_htrans;
  logic [2:0]  i_hsize;
  logic [3:0]  i_eng_ep, i_eng_pid;
  logic [5:0]  o_eng_slot;
  logic [6:0]  i_stat_evt;
  logic [7:0]  i_err_evt;
  logic [9:0]  i_eng_bc, o_eng_count;
  logic [15:0] o_eng_addr;
  logic [31:0] i_haddr, i_hwdata, o_hrdata, seed, rd, r;
  wire         i_hready = o_hreadyout;
  logic [31:0] mdesc [64];
  bit          ptr [32];
  int          failures, n_checks, md, ep, dir;

  ubd_top u_dut (.*);
  ubd_engine_model u_eng (.i_clk(i_clk), .o_stat(i_stat_evt), .o_err(i_err_evt), .o_req(i_eng_req),
    .o_done(i_eng_done), .o_ep(i_eng_ep), .o_dir(i_eng_dir), .o_pid(i_eng_pid), .o_bc(i_eng_bc));

  // ----
  // helpers
  // ----
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int slot_of(int e, int d);
    int p;
    p = ptr[2*e+d];
    if (md == 2) return 4*e + 2*d + p;
    if (md == 1) return (e == 0 && d == 0) ? p : 2*e + d + 1;
    return 2*e + d;
  endfunction
  // expected pointer register, one bit per {ep,dir}
  function automatic logic [31:0] ptr_word();
    logic [31:0] v;
    v = '0;
    for (int i = 0; i < 32; i++) v[i] = ptr[i];
    return v;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wait_rdy();
    int k;
    k = 0;
    @(negedge i_clk);
    while (o_hreadyout !== 1'b1) begin
      k++;
      if (k > 20) begin
        failures++;
        conclude();
      end
      @(negedge i_clk);
    end
  endtask
  // one single transfer; ready seen at the negedge is what the next edge samples
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    {i_hsel, i_htrans, i_hwrite, i_haddr, i_hsize} <= {1'b1, 2'h2, w, 20'h0_0000, a, ubd_pkg::HSIZE_WORD};
    wait_rdy();
    @(posedge i_clk);
    i_htrans <= 2'h0;
    i_hwdata <= d;
    wait_rdy();
    q = o_hrdata;
    @(posedge i_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, rd);
    chk(rd, e);
  endtask
  task automatic put(int s);
    mdesc[s] = rnd();
    wr(ubd_pkg::DESC_BASE + 12'(4*s), mdesc[s]);
  endtask
  task automatic look(int e, int d);
    logic [31:0] w;
    w = mdesc[slot_of(e, d)];
    u_eng.lookup(4'(e), 1'(d));
    @(negedge i_clk);
    chk(o_eng_valid, 32'h0000_0001);
    chk(o_eng_slot, slot_of(e, d));
    chk({o_eng_owned, o_eng_tsync_en, o_eng_toggle, o_eng_stall}, {w[7], w[3], w[6] & w[3], w[2]});
    chk({o_eng_addr, o_eng_count}, {w[31:16], w[1:0], w[15:8]});
    @(posedge i_clk);
  endtask
  task automatic fin(int e, int d);
    int s;
    logic [31:0] w;
    s = slot_of(e, d);
    w = mdesc[s];
    r = rnd();
    u_eng.complete(4'(e), 1'(d), r[3:0], r[13:4]);
    mdesc[s] = {w[31:16], r[11:4], 1'b0, w[6], r[3:0], r[13:12]};
    ptr[2*e+d] ^= 1'b1;
    rdc(ubd_pkg::DESC_BASE + 12'(4*s), mdesc[s]);
  endtask
  task automatic irq_is(input logic e);
    @(negedge i_clk);
    chk(o_irq, e);
    @(posedge i_clk);
  endtask

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  // ----
  // main sequence
  // ----
  initial begin
    {i_rst, i_hsel, i_htrans, i_hwrite, i_hsize, i_haddr, i_hwdata} = '0;
    i_rst = 1'b1;
    {failures, n_checks, md} = '0;
    seed = 32'h0000_0033;
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    wr(12'h020, 32'hFFFF_FFFF);
    for (int a = 0; a < 'h24; a += 4) rdc(12'(a), 32'h0000_0000);
    $display("done: reset and unmapped");
    for (int m = 0; m < 4; m++) begin
      md = m;
      wr(ubd_pkg::CFG_OFF, 32'(m));
      wr(ubd_pkg::CTRL_OFF, 32'h0000_0000);
      wr(ubd_pkg::CTRL_OFF, 32'h0000_0008);
      ptr = '{default: 1'b0};
      for (int k = 0; k < 10; k++) begin
        r = rnd();
        ep = (k < 4) ? 0 : (k < 6) ? 15 : r[3:0];
        dir = (k < 6) ? k / 2 % 2 : r[4];
        put(slot_of(ep, dir));
        look(ep, dir);
        fin(ep, dir);
      end
      rdc(ubd_pkg::PPSTAT_OFF, ptr_word());
    end
    $display("done: mapping");
    wr(ubd_pkg::SEN_OFF, 32'h0000_007F);
    u_eng.evt(7'h08, 8'h00);
    irq_is(1'b1);
    rdc(ubd_pkg::PFLAG2_OFF, 32'h0000_0020);
    rdc(ubd_pkg::SFLAG_OFF, 32'h0000_0008);
    wr(ubd_pkg::SFLAG_OFF, 32'h0000_0000);
    irq_is(1'b0);
    wr(ubd_pkg::SFLAG_OFF, 32'h0000_0042);
    rdc(ubd_pkg::SFLAG_OFF, 32'h0000_0040);
    irq_is(1'b1);
    wr(ubd_pkg::SEN_OFF, 32'h0000_0000);
    irq_is(1'b0);
    wr(ubd_pkg::SFLAG_OFF, 32'h0000_0000);
    wr(ubd_pkg::EEN_OFF, 32'h0000_0001);
    u_eng.evt(7'h00, 8'h03);
    rdc(ubd_pkg::EFLAG_OFF, 32'h0000_0003);
    rdc(ubd_pkg::SFLAG_OFF, 32'h0000_0002);
    wr(ubd_pkg::EFLAG_OFF, 32'h0000_0002);
    rdc(ubd_pkg::SFLAG_OFF, 32'h0000_0000);
    wr(ubd_pkg::EFLAG_OFF, 32'h0000_0000);
    $display("done: flags");
    wr(ubd_pkg::CTRL_OFF, 32'h0000_000A);
    rdc(ubd_pkg::CTRL_OFF, 32'h0000_000A);
    @(negedge i_clk);
    chk({o_enabled, o_suspend}, 32'h0000_0003);
    @(posedge i_clk);
    u_eng.evt(7'h7D, 8'hFF);
    u_eng.lookup(4'h1, 1'b0);
    @(negedge i_clk);
    chk(o_eng_valid, 32'h0000_0000);
    @(posedge i_clk);
    // a completion while suspended must not move any pointer
    u_eng.complete(4'h1, 1'b0, 4'hF, 10'h3FF);
    rdc(ubd_pkg::PPSTAT_OFF, ptr_word());
    rdc(ubd_pkg::SFLAG_OFF, 32'h0000_0004);
    rdc(ubd_pkg::EFLAG_OFF, 32'h0000_0000);
    wr(ubd_pkg::CTRL_OFF, 32'h0000_0008);
    @(negedge i_clk);
    chk({o_enabled, o_suspend}, 32'h0000_0002);
    @(posedge i_clk);
    put(slot_of(1, 0));
    look(1, 0);
    $display("done: suspend");
    conclude();
  end
endmodule
`default_nettype wire
